// >>> inc/pmd_defs.svh
`ifndef PMD_DEFS_SVH
`define PMD_DEFS_SVH

// ****************************************************************
// Register map (byte addresses on the APB)
// ****************************************************************
`define NUM_DIS_REGS      6
`define DIS_REG_STRIDE    8'h10
`define OFF_ANALOG        8'h00
`define OFF_COMPARATOR    8'h10
`define OFF_CAPCMP        8'h20
`define OFF_TIMER         8'h30
`define OFF_COMMS         8'h40
`define OFF_MISC          8'h50
`define OFF_CLK_STATUS    8'h80

// Alias slots inside each 16-byte disable window
`define ALIAS_WRITE       2'h0
`define ALIAS_CLR         2'h1
`define ALIAS_SET         2'h2
`define ALIAS_INV         2'h3

// ****************************************************************
// Implemented disable bits of each register
// ****************************************************************
`define MASK_ANALOG       32'h0000_1101
`define MASK_COMPARATOR   32'h0000_0007
`define MASK_CAPCMP       32'h001f_001f
`define MASK_TIMER        32'h0000_001f
`define MASK_COMMS        32'h0103_0303
`define MASK_MISC         32'h0001_0003

// ****************************************************************
// Reset values and fixed answers
// ****************************************************************
`define DIS_RESET         32'h0000_0000
`define SFR_INVALID_DATA  32'hffff_ffff
`define ADDR_W_MIN        8

`endif

// >>> inc/pmd_pkg.sv
package pmd_pkg;

  typedef logic [31:0] word_t;

  // APB request as seen by the slave
  typedef struct packed {
    logic       sel;
    logic       enable;
    logic       write;
    logic [7:0] addr;
    word_t      wdata;
    logic [3:0] strb;
  } apb_req_t;

  // Peripheral register access on the internal register path
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] target;
    word_t      rdata;
  } sfr_access_t;

endpackage

// >>> src/clock_gate_cell.sv
`timescale 1ns/1ps

module clock_gate_cell (
  // Clock and enable
  input  wire logic clk,
  input  wire logic enable,
  // Gated clock and the latched enable
  output logic      gclk,
  output logic      en_q
);

  logic en_latch;

  // Enable passes only while the clock is low, so no runt pulse
  always_latch begin
    if (!clk) begin
      en_latch <= enable;
    end
  end

  // Clock stops low while the enable is latched off
  assign gclk = clk & en_latch;
  assign en_q = en_latch;

endmodule

// >>> src/sfr_access_guard.sv
`timescale 1ns/1ps
`include "pmd_defs.svh"

module sfr_access_guard
  import pmd_pkg::*;
#(
  parameter int NBITS = 192
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Disable vector, one bit per register bit slot
  input  wire logic [NBITS-1:0] off,
  // Access from the core and the gated access to the peripheral
  input  wire sfr_access_t acc_in,
  output sfr_access_t      acc_out
);

  logic target_off;

  // Refuse a vector that an eight-bit slot number cannot address
  generate
    if (NBITS < 1 || NBITS > 256) begin : g_bad_nbits
      $error("sfr_access_guard: NBITS out of range");
    end
  endgenerate

  // Slots beyond the vector have no owner and are never blocked
  always_comb begin
    target_off = 1'b0;
    if (int'(acc_in.target) < NBITS) begin
      target_off = off[acc_in.target];
    end
  end

  // Writes to a stopped peripheral vanish; its reads give all ones
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acc_out <= '0;
    end else begin
      acc_out.wr     <= acc_in.wr & ~target_off;
      acc_out.rd     <= acc_in.rd;
      acc_out.target <= acc_in.target;
      acc_out.rdata  <= target_off ? `SFR_INVALID_DATA
                                   : acc_in.rdata;
    end
  end

endmodule

// >>> src/periph_module_disable.sv
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "pmd_defs.svh"

// Software must turn a module off, and let the USB block go idle,
// before setting its disable bit. This block sees neither the on bit
// nor the busy state of any module, so that ordering rests with the
// driver alone; a careless disable can leave a module half way.

module periph_module_disable
  import pmd_pkg::*;
#(
  parameter int                  ADDR_W          = 8,
  parameter logic [6*32-1:0]     VARIANT_PRESENT = {6*32{1'b1}}
) (
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              RESET,
  // APB slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  input  wire logic [3:0]        PSTRB,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // Peripheral clocks and disable flags, slot = register*32 + bit
  output logic      [6*32-1:0]   PERIPH_CLK,
  output logic      [6*32-1:0]   MODULE_OFF,
  // Peripheral register path from the core
  input  wire logic              SFR_WR_IN,
  input  wire logic              SFR_RD_IN,
  input  wire logic [7:0]        SFR_TARGET_IN,
  input  wire logic [31:0]       SFR_RDATA_IN,
  // Peripheral register path after the guard
  output logic                   SFR_WR_OUT,
  output logic                   SFR_RD_OUT,
  output logic      [7:0]        SFR_TARGET_OUT,
  output logic      [31:0]       SFR_RDATA_OUT
);

  // ****************************************************************
  // Constants and elaboration checks
  // ****************************************************************
  // Register count and slot count follow the register map
  localparam int NREG  = `NUM_DIS_REGS;
  localparam int NBITS = NREG * 32;

  // Bit layout of each register, first register in the low word
  localparam logic [NBITS-1:0] DOC_MASK = {
    `MASK_MISC,
    `MASK_COMMS,
    `MASK_TIMER,
    `MASK_CAPCMP,
    `MASK_COMPARATOR,
    `MASK_ANALOG
  };

  // Bits of peripherals absent on this variant are not built
  // Masking here keeps absent bits zero on every path that reads them
  localparam logic [NBITS-1:0] IMPL_MASK =
    DOC_MASK & VARIANT_PRESENT;

  // Refuse an address bus too narrow for the register map, and a
  // register count that the fixed-width ports cannot carry
  generate
    if (ADDR_W < `ADDR_W_MIN) begin : g_bad_addr_w
      $error("periph_module_disable: ADDR_W below the map size");
    end
    if (NREG != 6) begin : g_bad_nreg
      $error("periph_module_disable: ports are sized for six registers");
    end
  endgenerate

  // ****************************************************************
  // Declarations
  // ****************************************************************
  // Bus carrier
  apb_req_t          req;
  // Disable state and clock gates
  logic [NBITS-1:0]  dis_r;
  logic [NBITS-1:0]  dis_nxt;
  logic [NBITS-1:0]  gate_en_r;
  logic [NBITS-1:0]  gate_q;
  logic [NBITS-1:0]  gclk;
  // Address and write decode
  logic [31:0]       byte_mask;
  logic [31:0]       wbits;
  logic [3:0]        sel_reg;
  logic [1:0]        sel_alias;
  logic              in_dis_window;
  logic              in_status;
  logic [2:0]        status_idx;
  logic              addr_ok;
  logic              setup_phase;
  logic              write_now;
  // Bus answer
  logic [31:0]       rdata_nxt;
  logic              pready_r;
  logic [31:0]       prdata_r;
  logic              pslverr_r;
  // Flags towards the peripherals
  logic [NBITS-1:0]  module_off_r;
  // Peripheral register path
  sfr_access_t       sfr_in;
  sfr_access_t       sfr_out;

  // ****************************************************************
  // Bus request decode
  // ****************************************************************

  // Gather the APB inputs into one carrier
  // Upper address bits beyond the low byte are checked separately
  always_comb begin
    req        = '0;
    req.sel    = PSEL;
    req.enable = PENABLE;
    req.write  = PWRITE;
    req.addr   = PADDR[7:0];
    req.wdata  = PWDATA;
    req.strb   = PSTRB;
  end

  // Upper address bits must be zero for a hit
  // Misaligned offsets miss as well, so they end in an error
  generate
    if (ADDR_W > 8) begin : g_hi_addr
      logic hi_zero;
      assign hi_zero = (PADDR[ADDR_W-1:8] == '0);
      assign addr_ok = hi_zero & (in_dis_window | in_status)
                       & (req.addr[1:0] == 2'h0);
    end else begin : g_no_hi_addr
      assign addr_ok = (in_dis_window | in_status)
                       & (req.addr[1:0] == 2'h0);
    end
  endgenerate

  // Windows of 16 bytes hold a register and its clear/set/invert
  // Status words sit apart at the top of the map and are read only
  always_comb begin
    sel_reg       = req.addr[7:4];
    sel_alias     = req.addr[3:2];
    in_dis_window = (int'(sel_reg) < NREG);
    in_status     = (req.addr >= `OFF_CLK_STATUS) &&
                    (req.addr < `OFF_CLK_STATUS + 8'(4 * NREG));
    status_idx    = 3'(req.addr[4:2]);
  end

  // Setup cycle of a transfer, and the write edge of its access
  // A write lands only on the access edge, and never after an error
  assign setup_phase = req.sel & ~req.enable;
  assign write_now   = req.sel & req.enable & pready_r & req.write
                       & ~pslverr_r & in_dis_window;

  // Byte lanes that the master marks valid
  // Lanes left low keep their old bits in every write form
  always_comb begin
    for (int l = 0; l < 4; l++) begin
      byte_mask[l*8 +: 8] = {8{req.strb[l]}};
    end
    wbits = req.wdata & byte_mask;
  end

  // ****************************************************************
  // Disable registers
  // ****************************************************************

  // Next value of the addressed register for each write form
  // Clear, set and invert change only the bits written as 1, so a
  // driver need not read first and race another one on the same word
  always_comb begin
    dis_nxt = dis_r;
    if (write_now) begin
      for (int r = 0; r < NREG; r++) begin
        if (int'(sel_reg) == r) begin
          unique case (sel_alias)
            `ALIAS_WRITE: dis_nxt[r*32 +: 32] =
              (dis_r[r*32 +: 32] & ~byte_mask) | wbits;
            `ALIAS_CLR:   dis_nxt[r*32 +: 32] =
              dis_r[r*32 +: 32] & ~wbits;
            `ALIAS_SET:   dis_nxt[r*32 +: 32] =
              dis_r[r*32 +: 32] | wbits;
            `ALIAS_INV:   dis_nxt[r*32 +: 32] =
              dis_r[r*32 +: 32] ^ wbits;
          endcase
        end
      end
    end
    dis_nxt = dis_nxt & IMPL_MASK;
  end

  // All peripherals come out of reset enabled
  // so that no peripheral is left without a clock after a reset
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      dis_r <= {NREG{`DIS_RESET}};
    end else begin
      dis_r <= dis_nxt;
    end
  end

  // Flags towards the peripherals follow the stored bits
  // One cycle late, but free of glitches towards every peripheral
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      module_off_r <= '0;
    end else begin
      module_off_r <= dis_r;
    end
  end

  // ****************************************************************
  // Clock gating
  // ****************************************************************

  // Enable is a flop so the latch sees a clean level each low phase
  // Stop latency is the write edge, this flop and the next low phase;
  // a peripheral cannot count on a faster stop
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      gate_en_r <= IMPL_MASK;
    end else begin
      gate_en_r <= ~dis_r & IMPL_MASK;
    end
  end

  // One gate per implemented slot; absent slots stay low
  // Absent slots get no latch at all, which saves area on small parts
  generate
    for (genvar s = 0; s < NBITS; s++) begin : g_gate
      if (IMPL_MASK[s]) begin : g_cell
        clock_gate_cell u_gate (
          .clk    (CLK),
          .enable (gate_en_r[s]),
          .gclk   (gclk[s]),
          .en_q   (gate_q[s])
        );
      end else begin : g_none
        assign gclk[s]   = 1'b0;
        assign gate_q[s] = 1'b0;
      end
    end
  endgenerate

  // ****************************************************************
  // Register reads and the bus answer
  // ****************************************************************

  // Read data: disable words, or which clocks are running now
  // Status shows the latched enables, so software sees a stop take hold
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    for (int r = 0; r < NREG; r++) begin
      if (in_dis_window && int'(sel_reg) == r) begin
        rdata_nxt = dis_r[r*32 +: 32];
      end
      if (in_status && int'(status_idx) == r) begin
        rdata_nxt = gate_q[r*32 +: 32];
      end
    end
  end

  // One wait-free access: answer is ready in the first access cycle
  // Errors come with the same timing, so no master ever waits longer
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= setup_phase;
    end
  end

  // Data and error are captured in the setup cycle and then held
  // Holding them until select drops lets a slow master sample late
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup_phase) begin
      prdata_r  <= (addr_ok && !req.write) ? rdata_nxt : 32'h0000_0000;
      pslverr_r <= ~addr_ok;
    end else if (!req.sel) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Peripheral register guard
  // ****************************************************************

  // Core side accesses are checked against the stored disable bits
  // The stored bits act one cycle before the flags the peripherals
  // see, so the guard closes no later than the clock stops
  always_comb begin
    sfr_in        = '0;
    sfr_in.wr     = SFR_WR_IN;
    sfr_in.rd     = SFR_RD_IN;
    sfr_in.target = SFR_TARGET_IN;
    sfr_in.rdata  = SFR_RDATA_IN;
  end

  // Guard registers the path, so each access takes one extra cycle
  sfr_access_guard #(
    .NBITS (NBITS)
  ) u_guard (
    .clk     (CLK),
    .reset   (RESET),
    .off     (dis_r),
    .acc_in  (sfr_in),
    .acc_out (sfr_out)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Gated clocks cannot come from a flop; all else is registered
  // A flop there would halve the rate, so the gate drives the pin
  assign PRDATA         = prdata_r;
  assign PREADY         = pready_r;
  assign PSLVERR        = pslverr_r;
  assign PERIPH_CLK     = gclk;
  assign MODULE_OFF     = module_off_r;
  assign SFR_WR_OUT     = sfr_out.wr;
  assign SFR_RD_OUT     = sfr_out.rd;
  assign SFR_TARGET_OUT = sfr_out.target;
  assign SFR_RDATA_OUT  = sfr_out.rdata;

endmodule

// >>> tb/pmd_properties.sv
`timescale 1ns/1ps
`include "pmd_defs.svh"
// ****
// Port checker
// ****
module pmd_properties #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic              CLK,
  input wire logic              RESET,
  // APB
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic              PREADY,
  input wire logic              PSLVERR,
  // Disable flags
  input wire logic [6*32-1:0]   MODULE_OFF,
  // Register path
  input wire logic              SFR_WR_IN,
  input wire logic              SFR_RD_IN,
  input wire logic [7:0]        SFR_TARGET_IN,
  input wire logic [31:0]       SFR_RDATA_IN,
  input wire logic              SFR_WR_OUT,
  input wire logic [31:0]       SFR_RDATA_OUT
);
  localparam logic [191:0] IMPL = {`MASK_MISC, `MASK_COMMS, `MASK_TIMER,
                                   `MASK_CAPCMP, `MASK_COMPARATOR,
                                   `MASK_ANALOG};
  // One domain, so clock and reset are given once
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  ready_after_setup_a: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  ready_single_a: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  off_after_write_a:
    assert property ($changed(MODULE_OFF) |->
                     $past(PSEL && PENABLE && PREADY && PWRITE, 2))
    else $error("disable flags moved without a write");
  absent_bits_zero_a: assert property ((MODULE_OFF & ~IMPL) == '0)
    else $error("absent disable bit set");
  sfr_write_gate_a:
    assert property (SFR_WR_IN && SFR_TARGET_IN < 8'd192 |=>
                     SFR_WR_OUT == !MODULE_OFF[$past(SFR_TARGET_IN)])
    else $error("register write gating wrong");
  sfr_read_guard_a:
    assert property (SFR_RD_IN && SFR_TARGET_IN < 8'd192 |=>
      SFR_RDATA_OUT == (MODULE_OFF[$past(SFR_TARGET_IN)] ?
                        32'hffff_ffff : $past(SFR_RDATA_IN)))
    else $error("register read guard wrong");
  sfr_no_spurious_a: assert property (!SFR_WR_IN |=> !SFR_WR_OUT)
    else $error("write out without write in");
  misaligned_error_a:
    assert property (PSEL && !PENABLE && PADDR[1:0] != 2'h0 |=>
                     PREADY && PSLVERR)
    else $error("misaligned access not refused");

  // Main scenarios reached
  cover property (PSEL && PENABLE && PREADY && PWRITE);
  cover property ($changed(MODULE_OFF));
  cover property (PREADY && PSLVERR);
endmodule

bind periph_module_disable pmd_properties #(.ADDR_W(ADDR_W)) chk (
  .CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .MODULE_OFF(MODULE_OFF), .SFR_WR_IN(SFR_WR_IN), .SFR_RD_IN(SFR_RD_IN),
  .SFR_TARGET_IN(SFR_TARGET_IN), .SFR_RDATA_IN(SFR_RDATA_IN),
  .SFR_WR_OUT(SFR_WR_OUT), .SFR_RDATA_OUT(SFR_RDATA_OUT));

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb
  import pmd_pkg::*;
;
  // USB slot removed to model a smaller variant
  localparam logic [191:0] VP = ~(192'h1 << 152);
  logic         CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic         SFR_WR_IN, SFR_RD_IN, SFR_WR_OUT, SFR_RD_OUT, er;
  logic [7:0]   PADDR, SFR_TARGET_IN, SFR_TARGET_OUT;
  logic [3:0]   PSTRB, stb;
  word_t        PWDATA, PRDATA, SFR_RDATA_IN, SFR_RDATA_OUT, lf, rd;
  logic [191:0] PERIPH_CLK, MODULE_OFF;
  word_t        msk [6];
  word_t        mdl [6];
  int           err_total, num_checks, i;

  periph_module_disable #(.VARIANT_PRESENT(VP)) dut (
    .CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PERIPH_CLK(PERIPH_CLK), .MODULE_OFF(MODULE_OFF),
    .SFR_WR_IN(SFR_WR_IN), .SFR_RD_IN(SFR_RD_IN),
    .SFR_TARGET_IN(SFR_TARGET_IN), .SFR_RDATA_IN(SFR_RDATA_IN),
    .SFR_WR_OUT(SFR_WR_OUT), .SFR_RD_OUT(SFR_RD_OUT),
    .SFR_TARGET_OUT(SFR_TARGET_OUT), .SFR_RDATA_OUT(SFR_RDATA_OUT));

  // 200 MHz clock
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  function automatic word_t lfsr(word_t s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Byte lanes of a strobe as a bit mask
  function automatic word_t lanes(logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // Plain write, clear, set and invert aliases; lm marks live lanes
  function automatic word_t upd(word_t o, word_t d, int al, word_t m,
                                word_t lm);
    case (al)
      0: return ((o & ~lm) | (d & lm)) & m;
      1: return o & ~(d & lm);
      2: return (o | (d & lm)) & m;
      default: return (o ^ (d & lm)) & m;
    endcase
  endfunction

  task automatic check(input string nm, input word_t seen, input word_t exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; ready and data are taken at the same rising edge
  task automatic apb(input logic wr, input int a, input word_t d);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= 8'(a);
    PWDATA <= d;
    PSTRB <= stb;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // Read just after the edge, outputs still hold what it sampled
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // Read back, then look at flags, clocks in both phases and the guard
  task automatic verify(input int r);
    logic       b;
    logic [7:0] t;
    apb(1'b0, r * 16, '0);
    check("reg", rd, mdl[r]);
    check("err", {31'h0, er}, '0);
    repeat (3) @(posedge CLK);
    #1;
    check("off", MODULE_OFF[r*32 +: 32], mdl[r]);
    check("clk hi", PERIPH_CLK[r*32 +: 32], ~mdl[r] & msk[r]);
    @(negedge CLK);
    #1;
    check("clk lo", PERIPH_CLK[r*32 +: 32], '0);
    // Status words show which gates are open
    apb(1'b0, 8'h80 + r * 4, '0);
    check("status", rd, ~mdl[r] & msk[r]);
    check("status err", {31'h0, er}, '0);
    b = mdl[r][lf[4:0]];
    t = 8'(r * 32) + 8'(lf[4:0]);
    @(posedge CLK);
    SFR_WR_IN <= 1'b1;
    SFR_RD_IN <= 1'b1;
    SFR_TARGET_IN <= t;
    SFR_RDATA_IN <= lf;
    @(posedge CLK);
    SFR_WR_IN <= 1'b0;
    SFR_RD_IN <= 1'b0;
    @(negedge CLK);
    check("sfr wr", {31'h0, SFR_WR_OUT}, {31'h0, !b});
    check("sfr rd", SFR_RDATA_OUT, b ? 32'hffff_ffff : lf);
    check("sfr rd out", {31'h0, SFR_RD_OUT}, 32'h1);
    check("sfr target", {24'h0, SFR_TARGET_OUT}, {24'h0, t});
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    {PSEL, PENABLE, PWRITE, SFR_WR_IN, SFR_RD_IN} = '0;
    {PADDR, SFR_TARGET_IN, PWDATA, SFR_RDATA_IN} = '0;
    PSTRB = 4'hf;
    stb = 4'hf;
    RESET = 1'b1;
    lf = 32'hbb29;
    msk[0] = 32'h0000_1101;
    msk[1] = 32'h0000_0007;
    msk[2] = 32'h001f_001f;
    msk[3] = 32'h0000_001f;
    msk[4] = 32'h0003_0303;
    msk[5] = 32'h0001_0003;
    mdl = '{default: '0};
    repeat (10) @(posedge CLK);
    RESET <= 1'b0;
    for (i = 0; i < 6; i++) verify(i);
    // All ones shows exactly which bits exist
    for (i = 0; i < 6; i++) begin
      apb(1'b1, i * 16, '1);
      mdl[i] = msk[i];
      verify(i);
    end
    for (int k = 0; k < 48; k++) begin
      lf = lfsr(lf);
      i = lf[15:8] % 6;
      stb = (k < 8) ? 4'hf : lf[27:24];
      // The bench drives no peripheral access while the bits move
      apb(1'b1, i * 16 + (k % 4) * 4, lf);
      mdl[i] = upd(mdl[i], lf, k % 4, msk[i], lanes(stb));
      lf = lfsr(lf);
      verify(i);
    end
    stb = 4'hf;
    // Unmapped and misaligned accesses are refused and write nothing
    apb(1'b1, 8'h60, '1);
    check("unmapped", {31'h0, er}, 32'h1);
    apb(1'b1, 8'h02, '1);
    check("misalign", {31'h0, er}, 32'h1);
    verify(0);
    // Reset in mid-run puts every peripheral back on
    @(posedge CLK);
    RESET <= 1'b1;
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    mdl = '{default: '0};
    for (i = 0; i < 6; i++) verify(i);
    close_out;
  end

  // Watchdog
  initial begin
    #100000;
    err_total++;
    close_out;
  end
endmodule
